// ---- acr_pkg.sv ----
/*
  Constants for the audio codec control register bank: offsets, reset values,
  field positions, masks and the supported sample rates.
  Assumes a 16-bit register word and a 7-bit even register index.
*/
package acr_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int LVL_W  = 7;
  localparam int ATT_W  = 8;
  localparam int NCHAN  = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_SOFT_RESET = 7'h00;
  localparam logic [ADDR_W-1:0] OFS_POWER      = 7'h26;
  localparam logic [ADDR_W-1:0] OFS_IDENT      = 7'h28;
  localparam logic [ADDR_W-1:0] OFS_EXT_CTRL   = 7'h2A;
  localparam logic [ADDR_W-1:0] OFS_FRONT_RATE = 7'h2C;
  localparam logic [ADDR_W-1:0] OFS_SURR_RATE  = 7'h2E;
  localparam logic [ADDR_W-1:0] OFS_LOWF_RATE  = 7'h30;
  localparam logic [ADDR_W-1:0] OFS_CONV_A     = 7'h32;
  localparam logic [ADDR_W-1:0] OFS_CONV_B     = 7'h34;
  localparam logic [ADDR_W-1:0] OFS_VOL_CS     = 7'h36;
  localparam logic [ADDR_W-1:0] OFS_VOL_SP     = 7'h38;
  localparam logic [ADDR_W-1:0] OFS_VENDOR     = 7'h5A;

  // Reset values
  localparam logic [DATA_W-1:0] RST_POWER    = 16'h800E;
  localparam logic [DATA_W-1:0] RST_EXT_CTRL = 16'h01C0;
  localparam logic [DATA_W-1:0] RST_VOLUME   = 16'h8080;
  localparam logic [DATA_W-1:0] RST_VENDOR   = 16'h1170;

  // Power control fields
  localparam int PWR_SILENCE_BIT = 12;
  localparam int PWR_HALT_BIT    = 13;
  localparam int PWR_AMP_BIT     = 15;
  localparam logic [DATA_W-1:0] PWR_FIXED_MASK = 16'h000F;
  localparam logic [DATA_W-1:0] PWR_FIXED_VAL  = 16'h000E;
  localparam logic [DATA_W-1:0] PWR_VALID      = 16'hB00F;

  // Identification fields
  localparam logic [DATA_W-1:0] IDENT_BASE = 16'h01C3;
  localparam int IDENT_IDX_BIT = 14;

  // Extended control fields
  localparam int EXT_VAR_BIT = 0;
  localparam int EXT_DBL_BIT = 1;
  localparam logic [DATA_W-1:0] EXT_READY_MASK = 16'h03C0;
  localparam logic [DATA_W-1:0] EXT_READY_VAL  = 16'h01C0;
  localparam logic [DATA_W-1:0] EXT_VALID      = 16'h03C3;

  // Sample rates
  localparam logic [DATA_W-1:0] RATE_48K = 16'hBB80;
  localparam logic [DATA_W-1:0] RATE_44K = 16'hAC44;
  localparam logic [DATA_W-1:0] RATE_MID = 16'hB3E2;

  // Volume fields
  localparam int VOL_HI_MUTE = 15;
  localparam int VOL_HI_LSB  = 8;
  localparam int VOL_LO_MUTE = 7;
  localparam int VOL_LO_LSB  = 0;
  localparam logic [LVL_W-1:0] LVL_SILENT   = 7'h68;
  localparam logic [ATT_W-1:0] STEP_FC_HALF = 8'h03;
  localparam logic [ATT_W-1:0] STEP_EX_HALF = 8'h02;
  localparam logic [ATT_W-1:0] ATT_MAX      = 8'hFF;

  // Vendor configuration fields
  localparam int VEN_FULL_COMP = 0;
  localparam int VEN_GAIN_HI   = 3;
  localparam int VEN_TRUTH     = 6;
  localparam int VEN_MCLK      = 9;
  localparam int VEN_THR_LO    = 12;
  localparam int VEN_THR_HI    = 13;
  localparam int VEN_RATIO_DBG = 14;
  localparam int VEN_BYPASS    = 15;

endpackage : acr_pkg

// ---- acr_rate_round.sv ----
/*
  Rounds a written front sample rate onto the supported pair of rates.
  Assumes a combinational use inside the register write path.
*/
`timescale 1ns/10ps
`default_nettype none
module acr_rate_round
  import acr_pkg::*;
(
  input  wire logic [acr_pkg::DATA_W-1:0] wr_value,
  output logic      [acr_pkg::DATA_W-1:0] rounded
);

  // Nearest supported rate, ties go to the higher one
  always_comb
  begin
    if (wr_value == RATE_48K || wr_value == RATE_44K)
      rounded = wr_value;
    else if (wr_value >= RATE_MID)
      rounded = RATE_48K;
    else
      rounded = RATE_44K;
  end

endmodule : acr_rate_round
`default_nettype wire

// ---- acr_vol_decode.sv ----
/*
  Decodes one channel level and mute into attenuation in half-dB units.
  Assumes the caller registers the outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module acr_vol_decode
  import acr_pkg::*;
(
  input  wire logic [acr_pkg::LVL_W-1:0] level,
  input  wire logic                      mute,
  input  wire logic                      full_comp,
  output logic      [acr_pkg::ATT_W-1:0] atten_half_db,
  output logic                           silent
);

  // Attenuation only; six bits at 1.5 dB or seven bits at 1 dB
  always_comb
  begin
    if (full_comp)
    begin
      atten_half_db = 8'(level[5:0] * STEP_FC_HALF);
      silent        = mute;
    end
    else if (level >= LVL_SILENT)
    begin
      atten_half_db = ATT_MAX;
      silent        = 1'b1;
    end
    else
    begin
      atten_half_db = 8'(level * STEP_EX_HALF);
      silent        = mute;
    end
  end

endmodule : acr_vol_decode
`default_nettype wire

// ---- acr_regs.sv ----
/*
  Audio codec control register bank with link output silencing, core clock
  halt request, rate rounding and mirroring, and extra-channel volume decode.
  Assumes a link controller that hands over decoded 16-bit register accesses
  on core_clk, and a link bit clock pin sampled by core_clk.
*/
//
// Contract
// - Silence bit holds link clock, data low
// - Halt bit stops internal processing clock
// - Amplifier powerdown bit resets one, readable
// - Power writes force bits three-zero to 1110
// - Identification register fixed, reports feature bits
// - Index bit follows select pin, next zero
// - Bit zero variable rate, bit one double
// - Readiness bits always stored as 0111
// - Front rate rounds to nearest, ties higher
// - Surround, low-frequency rates mirror front rate
// - Double rate doubles the playing rate
// - Any register reset restores 48 kHz rates
// - Converter input rates always read 48 kHz
// - Two volume registers hold four channels
// - Levels attenuate only, per-channel mute
// - Volume registers reset to muted, zero attenuation
// - Vendor register field placement
// - Compliance mode: six bits, 1.5 dB steps
// - Vendor mode: 1 dB steps, 68h silent
// - Compliance mode reads zero reserved bits (masked on power and extended control reads only)
`timescale 1ns/10ps
`default_nettype none
module acr_regs
  import acr_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        reg_wr_en,
  input  wire logic                        reg_rd_en,
  input  wire logic [acr_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [acr_pkg::DATA_W-1:0]  reg_wdata,
  output logic      [acr_pkg::DATA_W-1:0]  reg_rdata,
  output logic                             reg_ack,
  input  wire logic                        secondary_select_pin,
  input  wire logic                        link_bit_clk_in,
  input  wire logic                        tx_sdata,
  output logic                             link_bit_clk_out,
  output logic                             link_sdata_in_out,
  output logic                             core_clk_run,
  output logic                             amplifier_powerdown_request,
  output logic                             variable_rate_enable,
  output logic                             double_rate_enable,
  output logic      [acr_pkg::DATA_W:0]    play_rate_hz,
  output logic      [acr_pkg::NCHAN*acr_pkg::ATT_W-1:0] chan_atten,
  output logic      [acr_pkg::NCHAN-1:0]   chan_silent,
  output logic                             full_compliance_select,
  output logic                             amp_gain_upper,
  output logic                             output_truth_table_select,
  output logic                             master_clock_out_rate,
  output logic                             rate_threshold_low,
  output logic                             rate_threshold_high,
  output logic                             ratio_debug,
  output logic                             resampler_bypass
);

  import acr_pkg::*;

  logic [DATA_W-1:0] power_control_status_ff;
  logic [DATA_W-1:0] extended_feature_control_ff;
  logic [DATA_W-1:0] front_sample_rate_ff;
  logic [DATA_W-1:0] center_sub_volume_ff;
  logic [DATA_W-1:0] surround_pair_volume_ff;
  logic [DATA_W-1:0] vendor_configuration_ff;
  logic [DATA_W-1:0] reg_rdata_ff;
  logic              reg_ack_ff;
  logic [DATA_W-1:0] rate_rounded;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] ident_value;
  logic              soft_rst_wr;
  logic              reg_clear;
  logic              sel_meta_ff;
  logic              sel_sync_ff;
  logic              bclk_meta_ff;
  logic              bclk_sync_ff;
  logic              bclk_prev_ff;
  logic              bclk_rise;
  logic              link_bit_clk_ff;
  logic              link_sdata_ff;
  logic [DATA_W:0]   play_rate_ff;
  logic [NCHAN*ATT_W-1:0] atten_comb;
  logic [NCHAN-1:0]  silent_comb;
  logic [NCHAN*ATT_W-1:0] chan_atten_ff;
  logic [NCHAN-1:0]  chan_silent_ff;
  logic [LVL_W-1:0]  chan_level [NCHAN];
  logic [NCHAN-1:0]  chan_mute;
  logic              full_comp;

  // Write strobe decode
  function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
    wr_hit = reg_wr_en && (reg_addr == ofs);
  endfunction : wr_hit

  // Any write to the reset index reverts every register
  assign soft_rst_wr = reg_wr_en && (reg_addr == OFS_SOFT_RESET);
  assign reg_clear   = sys_rst | soft_rst_wr;
  assign full_comp   = ~vendor_configuration_ff[VEN_FULL_COMP];

  // Secondary select pin synchroniser
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sel_meta_ff <= 1'b0;
      sel_sync_ff <= 1'b0;
    end
    else
    begin
      sel_meta_ff <= secondary_select_pin;
      sel_sync_ff <= sel_meta_ff;
    end
  end

  // Link bit clock synchroniser and edge history
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      bclk_meta_ff <= 1'b0;
      bclk_sync_ff <= 1'b0;
      bclk_prev_ff <= 1'b0;
    end
    else
    begin
      bclk_meta_ff <= link_bit_clk_in;
      bclk_sync_ff <= bclk_meta_ff;
      bclk_prev_ff <= bclk_sync_ff;
    end
  end

  assign bclk_rise = bclk_sync_ff & ~bclk_prev_ff;

  // Link outputs; data launched on bit clock rise, both held low when silenced
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      link_bit_clk_ff <= 1'b0;
      link_sdata_ff   <= 1'b0;
    end
    else if (power_control_status_ff[PWR_SILENCE_BIT])
    begin
      link_bit_clk_ff <= 1'b0;
      link_sdata_ff   <= 1'b0;
    end
    else
    begin
      link_bit_clk_ff <= bclk_sync_ff;
      if (bclk_rise)
        link_sdata_ff <= tx_sdata;
    end
  end

  // Power control: low nibble forced, silence bit sticks until a reset
  always_ff @(posedge core_clk)
  begin
    if (reg_clear)
      power_control_status_ff <= RST_POWER;
    else if (wr_hit(OFS_POWER))
    begin
      power_control_status_ff <= (reg_wdata & ~PWR_FIXED_MASK) | PWR_FIXED_VAL;
      if (power_control_status_ff[PWR_SILENCE_BIT])
        power_control_status_ff[PWR_SILENCE_BIT] <= 1'b1;
    end
  end

  // Extended control: readiness bits always stored as the fixed pattern
  always_ff @(posedge core_clk)
  begin
    if (reg_clear)
      extended_feature_control_ff <= RST_EXT_CTRL;
    else if (wr_hit(OFS_EXT_CTRL))
      extended_feature_control_ff <= (reg_wdata & ~EXT_READY_MASK) | EXT_READY_VAL;
  end

  acr_rate_round u_rate_round
  (
    .wr_value (reg_wdata),
    .rounded  (rate_rounded)
  );

  // Front rate; surround and low-frequency rates read this same word
  always_ff @(posedge core_clk)
  begin
    if (reg_clear)
      front_sample_rate_ff <= RATE_48K;
    else if (wr_hit(OFS_FRONT_RATE))
      front_sample_rate_ff <= rate_rounded;
  end

  // Extra-channel volume registers
  always_ff @(posedge core_clk)
  begin
    if (reg_clear)
    begin
      center_sub_volume_ff    <= RST_VOLUME;
      surround_pair_volume_ff <= RST_VOLUME;
    end
    else
    begin
      if (wr_hit(OFS_VOL_CS))
        center_sub_volume_ff <= reg_wdata;
      if (wr_hit(OFS_VOL_SP))
        surround_pair_volume_ff <= reg_wdata;
    end
  end

  // Vendor configuration register
  always_ff @(posedge core_clk)
  begin
    if (reg_clear)
      vendor_configuration_ff <= RST_VENDOR;
    else if (wr_hit(OFS_VENDOR))
      vendor_configuration_ff <= reg_wdata;
  end

  // Identification word; writes to it are not decoded anywhere
  always_comb
  begin
    ident_value = IDENT_BASE;
    ident_value[IDENT_IDX_BIT] = sel_sync_ff;
  end

  // Read multiplexer with reserved-bit masking in compliance mode
  always_comb
  begin
    nxt_rdata = '0;
    case (reg_addr)
      OFS_POWER:
        nxt_rdata = full_comp ? (power_control_status_ff & PWR_VALID)
                              : power_control_status_ff;
      OFS_IDENT:
        nxt_rdata = ident_value;
      OFS_EXT_CTRL:
        nxt_rdata = full_comp ? (extended_feature_control_ff & EXT_VALID)
                              : extended_feature_control_ff;
      OFS_FRONT_RATE, OFS_SURR_RATE, OFS_LOWF_RATE:
        nxt_rdata = front_sample_rate_ff;
      OFS_CONV_A, OFS_CONV_B:
        nxt_rdata = RATE_48K;
      OFS_VOL_CS:
        nxt_rdata = center_sub_volume_ff;
      OFS_VOL_SP:
        nxt_rdata = surround_pair_volume_ff;
      OFS_VENDOR:
        nxt_rdata = vendor_configuration_ff;
      default:
        nxt_rdata = '0;
    endcase
  end

  // Registered read data and one-cycle acknowledge for reads and writes
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata_ff <= '0;
      reg_ack_ff   <= 1'b0;
    end
    else
    begin
      reg_ack_ff <= reg_rd_en | reg_wr_en;
      if (reg_rd_en)
        reg_rdata_ff <= nxt_rdata;
    end
  end

  // Playing rate, doubled in double rate mode
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      play_rate_ff <= {1'b0, RATE_48K};
    else if (extended_feature_control_ff[EXT_DBL_BIT])
      play_rate_ff <= {front_sample_rate_ff, 1'b0};
    else
      play_rate_ff <= {1'b0, front_sample_rate_ff};
  end

  // Channel fields: sub, center, left rear, right rear
  assign chan_level[0] = center_sub_volume_ff[VOL_HI_LSB +: LVL_W];
  assign chan_level[1] = center_sub_volume_ff[VOL_LO_LSB +: LVL_W];
  assign chan_level[2] = surround_pair_volume_ff[VOL_HI_LSB +: LVL_W];
  assign chan_level[3] = surround_pair_volume_ff[VOL_LO_LSB +: LVL_W];
  assign chan_mute = {surround_pair_volume_ff[VOL_LO_MUTE], surround_pair_volume_ff[VOL_HI_MUTE],
                      center_sub_volume_ff[VOL_LO_MUTE], center_sub_volume_ff[VOL_HI_MUTE]};

  // One decoder per channel
  for (genvar gi = 0; gi < NCHAN; gi++)
  begin : g_chan
    acr_vol_decode u_vol
    (
      .level         (chan_level[gi]),
      .mute          (chan_mute[gi]),
      .full_comp     (full_comp),
      .atten_half_db (atten_comb[gi*ATT_W +: ATT_W]),
      .silent        (silent_comb[gi])
    );
  end

  // Registered channel controls
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      chan_atten_ff  <= '0;
      chan_silent_ff <= '1;
    end
    else
    begin
      chan_atten_ff  <= atten_comb;
      chan_silent_ff <= silent_comb;
    end
  end

  // Output assignments
  assign reg_rdata                   = reg_rdata_ff;
  assign reg_ack                     = reg_ack_ff;
  assign link_bit_clk_out            = link_bit_clk_ff;
  assign link_sdata_in_out           = link_sdata_ff;
  assign core_clk_run                = ~power_control_status_ff[PWR_HALT_BIT];
  assign amplifier_powerdown_request = power_control_status_ff[PWR_AMP_BIT];
  assign variable_rate_enable        = extended_feature_control_ff[EXT_VAR_BIT];
  assign double_rate_enable          = extended_feature_control_ff[EXT_DBL_BIT];
  assign play_rate_hz                = play_rate_ff;
  assign chan_atten                  = chan_atten_ff;
  assign chan_silent                 = chan_silent_ff;
  assign full_compliance_select      = vendor_configuration_ff[VEN_FULL_COMP];
  assign amp_gain_upper              = vendor_configuration_ff[VEN_GAIN_HI];
  assign output_truth_table_select   = vendor_configuration_ff[VEN_TRUTH];
  assign master_clock_out_rate       = vendor_configuration_ff[VEN_MCLK];
  assign rate_threshold_low          = vendor_configuration_ff[VEN_THR_LO];
  assign rate_threshold_high         = vendor_configuration_ff[VEN_THR_HI];
  assign ratio_debug                 = vendor_configuration_ff[VEN_RATIO_DBG];
  assign resampler_bypass            = vendor_configuration_ff[VEN_BYPASS];

  // Checks
  sequence s_silence_write;
    reg_wr_en && reg_addr == OFS_POWER && reg_wdata[PWR_SILENCE_BIT] && !reg_clear;
  endsequence

  sequence s_link_low;
    !link_bit_clk_out && !link_sdata_in_out;
  endsequence

  a_silence_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_silence_write ##1 (!reg_clear) |=> s_link_low)
    else $error("link outputs not held low while silenced");

  a_silence_sticks: assert property (@(posedge core_clk) disable iff (sys_rst)
    power_control_status_ff[PWR_SILENCE_BIT] && !reg_clear
      |=> power_control_status_ff[PWR_SILENCE_BIT])
    else $error("silence bit cleared without a reset");

  a_halt_output: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_POWER && !soft_rst_wr
      |=> core_clk_run == !$past(reg_wdata[PWR_HALT_BIT]))
    else $error("core clock run does not follow halt bit");

  a_power_nibble: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_POWER
      |=> (power_control_status_ff & PWR_FIXED_MASK) == PWR_FIXED_VAL
          && power_control_status_ff[PWR_AMP_BIT] == $past(reg_wdata[PWR_AMP_BIT]))
    else $error("power write not masked correctly");

  a_ident_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd_en && reg_addr == OFS_IDENT
      |=> reg_ack && reg_rdata == (IDENT_BASE | ($past(sel_sync_ff) << IDENT_IDX_BIT)))
    else $error("identification read wrong");

  a_ready_bits: assert property (@(posedge core_clk) disable iff (sys_rst)
    (extended_feature_control_ff & EXT_READY_MASK) == EXT_READY_VAL)
    else $error("readiness bits not 0111");

  a_rate_round: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_FRONT_RATE && reg_wdata >= RATE_MID
      |=> front_sample_rate_ff == RATE_48K)
    else $error("rate not rounded up to 48 kHz");

  a_rate_supported: assert property (@(posedge core_clk) disable iff (sys_rst)
    front_sample_rate_ff == RATE_48K || front_sample_rate_ff == RATE_44K)
    else $error("front rate holds an unsupported value");

  a_double_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
    double_rate_enable && $stable(front_sample_rate_ff) && $stable(double_rate_enable)
      |=> play_rate_hz == {$past(front_sample_rate_ff), 1'b0})
    else $error("double rate not applied");

  a_soft_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    soft_rst_wr |=> front_sample_rate_ff == RATE_48K && center_sub_volume_ff == RST_VOLUME)
    else $error("soft reset did not restore defaults");

  a_conv_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd_en && (reg_addr == OFS_CONV_A || reg_addr == OFS_CONV_B) |=> reg_rdata == RATE_48K)
    else $error("converter rate read not 48 kHz");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd_en && full_comp && reg_addr == OFS_POWER |=> (reg_rdata & ~PWR_VALID) == '0)
    else $error("reserved bits visible in compliance mode");

endmodule : acr_regs
`default_nettype wire

// ---- acr_link_host.sv ----
/*
  Link host model: makes the link bit clock during frames and the serial
  data, and watches the clock and data that come back from the device.
  Assumes the device takes the data on its synchronised clock rise.
*/
`timescale 1ns/10ps
`default_nettype none
module acr_link_host
(
  input  wire logic core_clk,
  input  wire logic run,
  input  wire logic bclk_ret,
  input  wire logic sdata_ret,
  output logic      bclk,
  output logic      sdata,
  output int        rises,
  output int        bad
);
  logic [7:0] pat;
  logic       prev;
  // Bit clock toggles every 80 ns while framing, parks low otherwise
  initial
  begin
    bclk = 1'b0;
    #3.3;
    forever
    begin
      #80;
      bclk = run ? ~bclk : 1'b0;
    end
  end
  // Pattern advances on the falling edge, so data is stable at each rise
  initial pat = 8'hB4;
  always @(negedge bclk) pat <= {pat[6:0], pat[7]};
  initial sdata = 1'b0;
  always @(posedge core_clk) sdata <= pat[7];
  // Count returned rises and check the returned data bit at each
  initial
  begin
    rises = 0;
    bad = 0;
    prev = 1'b0;
  end
  always @(posedge core_clk)
  begin
    prev <= bclk_ret;
    if (bclk_ret && !prev)
    begin
      rises <= rises + 1;
      if (sdata_ret !== sdata) bad <= bad + 1;
    end
  end
endmodule : acr_link_host
`default_nettype wire

// ---- acr_regs_test.sv ----
/*
  Self-checking bench for the register bank: register accesses by task,
  link traffic from the host model.
  Assumes one access per two cycles and ack one cycle after the request.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, sn); end end
module acr_regs_test;
  import acr_pkg::*;
  logic core_clk, sys_rst, reg_wr_en, reg_rd_en, sel_pin, run, ack;
  logic bclk_in, sdata_tx, bclk_out, sdata_out, clk_run, amp_req, var_en, dbl_en;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, q;
  logic [DATA_W:0]   play_rate;
  logic [31:0]       chan_atten;
  logic [3:0]        chan_silent;
  logic [7:0]        ven;
  int miscompares = 0, total_checks = 0, rises, bad, n0;
  logic [6:0]  rst_a [12] = '{7'h26, 7'h28, 7'h2A, 7'h2C, 7'h2E, 7'h30, 7'h32, 7'h34,
                             7'h36, 7'h38, 7'h5A, 7'h7E};
  logic [15:0] rst_v [12] = '{16'h800E, 16'h01C3, 16'h01C0, 16'hBB80, 16'hBB80, 16'hBB80,
                             16'hBB80, 16'hBB80, 16'h8080, 16'h8080, 16'h1170, 16'h0000};
  logic [15:0] rate_w [6] = '{16'hAC44, 16'hBB80, 16'hB3E2, 16'hB3E1, 16'h0000, 16'hFFFF};
  logic [15:0] rate_e [6] = '{16'hAC44, 16'hBB80, 16'hBB80, 16'hAC44, 16'hAC44, 16'hBB80};
  // Device under test
  acr_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(ack), .secondary_select_pin(sel_pin),
    .link_bit_clk_in(bclk_in), .tx_sdata(sdata_tx), .link_bit_clk_out(bclk_out),
    .link_sdata_in_out(sdata_out), .core_clk_run(clk_run),
    .amplifier_powerdown_request(amp_req), .variable_rate_enable(var_en),
    .double_rate_enable(dbl_en), .play_rate_hz(play_rate), .chan_atten(chan_atten),
    .chan_silent(chan_silent), .full_compliance_select(ven[0]), .amp_gain_upper(ven[1]),
    .output_truth_table_select(ven[2]), .master_clock_out_rate(ven[3]),
    .rate_threshold_low(ven[4]), .rate_threshold_high(ven[5]), .ratio_debug(ven[6]),
    .resampler_bypass(ven[7]));
  // Link host on the far side
  acr_link_host u_host (.core_clk(core_clk), .run(run), .bclk_ret(bclk_out),
    .sdata_ret(sdata_out), .bclk(bclk_in), .sdata(sdata_tx), .rises(rises), .bad(bad));
  // Core clock, 8 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // One register access; request pulses one cycle, answer checked with ack
  task automatic acc(input logic wr, input logic [6:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr_en <= wr;
    reg_rd_en <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    #1;
    `CHK("reg_ack", 1'b1, ack)
    q = reg_rdata;
  endtask : acc
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK("reg_rdata", e, q)
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  task close_out;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // Watchdog well beyond the expected run of about 950 cycles
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
  // Test sequence
  initial
  begin
    {reg_wr_en, reg_rd_en, sel_pin, reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    run = 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 12; i++) rd(rst_a[i], rst_v[i]);
    `CHK("amp_req", 1'b1, amp_req)
    `CHK("silent", 4'hF, chan_silent)
    n0 = rises;
    wait_cyc(200);
    `CHK("bclk_running", 1'b1, rises > n0 + 5)
    acc(1'b1, 7'h28, 16'hFFFF);
    @(posedge core_clk);
    sel_pin <= 1'b1;
    wait_cyc(4);
    rd(7'h28, 16'h41C3);
    acc(1'b1, 7'h26, 16'h4FF5);
    rd(7'h26, 16'h000E);
    `CHK("amp_req", 1'b0, amp_req)
    acc(1'b1, 7'h2A, 16'hFFFF);
    rd(7'h2A, 16'h01C3);
    `CHK("rate_enables", 2'b11, {var_en, dbl_en})
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, 7'h2C, rate_w[i]);
      rd(7'h2C, rate_e[i]);
      rd(7'h2E, rate_e[i]);
      rd(7'h30, rate_e[i]);
    end
    acc(1'b1, 7'h32, 16'h1234);
    rd(7'h32, 16'hBB80);
    wait_cyc(2);
    `CHK("play_rate", 17'h17700, play_rate)
    acc(1'b1, 7'h36, 16'h1F05);
    rd(7'h36, 16'h1F05);
    wait_cyc(2);
    `CHK("atten_fc", 16'h0F5D, chan_atten[15:0])
    `CHK("silent_fc", 4'hC, chan_silent)
    acc(1'b1, 7'h5A, 16'hF249);
    rd(7'h5A, 16'hF249);
    `CHK("vendor_bits", 8'hFF, ven)
    rd(7'h26, 16'h4FFE);
    rd(7'h2A, 16'hFDFF);
    acc(1'b1, 7'h38, 16'hE868);
    wait_cyc(2);
    `CHK("atten_vm", 32'hFFFF0A3E, chan_atten)
    `CHK("silent_vm", 4'hC, chan_silent)
    acc(1'b1, 7'h26, 16'h3000);
    wait_cyc(3);
    `CHK("clk_run", 1'b0, clk_run)
    n0 = rises;
    wait_cyc(200);
    `CHK("silenced", 3'b000, {rises != n0, bclk_out, sdata_out})
    acc(1'b1, 7'h26, 16'h0000);
    wait_cyc(200);
    `CHK("still_silenced", 3'b100, {clk_run, rises != n0, bclk_out})
    acc(1'b1, 7'h00, 16'h0000);
    wait_cyc(10);
    n0 = rises;
    wait_cyc(200);
    `CHK("resumed", 1'b1, rises > n0 + 5)
    rd(7'h2C, 16'hBB80);
    rd(7'h36, 16'h8080);
    rd(7'h26, 16'h800E);
    `CHK("link_data", 0, bad)
    close_out();
  end
endmodule : acr_regs_test
`default_nettype wire
